// file: design/tw_defs.svh
// Constants of the two-wire slave and software master block.
//------------------------------------------------------------------------------
// Behaviour
// - Writing one to the reset bit forces the slave engine idle; zero resumes.
// - Direction flag holds the master's read/write bit; one means slave transmits.
// - Byte-done flag sets per byte; any data register access clears it.
// - Four writable 7-bit slave addresses; first resets to 55H, others 7FH.
// - A second data access within one interrupt halts until the reset bit.
// - Pulses shorter than 50 ns on both lines are filtered out.
// - Repeated start accepted without stop, but only while slave is receiver.
// - In master mode the clock pin is always driven from the clock bit.
// - In master mode data pin drives the data bit when drive enable set.
// - With drive enable clear, data input bit latches the pin on clock rise.
// - Reset selects slave role; role bit one selects software master mode.
// - Valid start, matching address and read/write bit set byte-done.
// - Interrupt raised only with both enables set; vector is 003BH.
// - First byte in the data register is the address with read/write bit.
// - After a valid address the clock is held low until byte-done clears.
// - Byte-done sets only when the byte is acknowledged; not-acknowledge gives none.
// - Stop or not-acknowledge returns the slave idle; otherwise every byte flags.
// - Source bits: 00 start, 01 repeated start, 10 data, 11 stop.
// - With stop interrupt enable set, a stop after a matching address interrupts.
// - General call flag set by hardware on general call; software clears it.
//------------------------------------------------------------------------------
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

`define TW_ADDR_CONTROL 8'he8
`define TW_ADDR_SECOND  8'h91
`define TW_ADDR_THIRD   8'h92
`define TW_ADDR_FOURTH  8'h93
`define TW_ADDR_DATA    8'h9a
`define TW_ADDR_FIRST   8'h9b

`define TW_RST_FIRST    8'h55
`define TW_RST_OTHER    8'h7f
`define TW_RST_DATA     8'h00

`define TW_BIT_HI       7
`define TW_BIT_MID      6
`define TW_BIT_SRC_HI   5
`define TW_BIT_SRC_LO   4
`define TW_BIT_ROLE     3
`define TW_BIT_RESET    2
`define TW_BIT_DIR      1
`define TW_BIT_DONE     0

`define TW_SRC_START    2'h0
`define TW_SRC_RESTART  2'h1
`define TW_SRC_DATA     2'h2
`define TW_SRC_STOP     2'h3

`define TW_IRQ_VECTOR   16'h003b
`define TW_GEN_CALL     7'h00
`define TW_BITS_BYTE    4'h8
`define TW_FILTER_NS    50
`define TW_SYS_CLK_NS   100

`endif

// file: design/tw_pkg.sv
// Types of the two-wire slave and software master block.
package tw_pkg;

   typedef enum logic [7:0] {
      TW_IDLE = 8'h01,
      TW_ADDR = 8'h02,
      TW_AACK = 8'h04,
      TW_RX   = 8'h08,
      TW_RACK = 8'h10,
      TW_TX   = 8'h20,
      TW_TACK = 8'h40,
      TW_HOLD = 8'h80
   } tw_state_type;

endpackage

// file: design/tw_two_wire.sv
// Two-wire hardware slave with software master mode behind special function registers.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

module tw_two_wire
   import tw_pkg::*;
#(
   parameter int LINK_PERIOD_PS = 6000
) (
   input  wire logic       sys_clk,          // Core clock.
   input  wire logic       reset,            // Synchronous reset, active high.
   input  wire logic       link_clk,         // Line sampling clock.
   input  wire logic [7:0] sfr_addr,         // Register address.
   input  wire logic       sfr_wr,           // Register write strobe.
   input  wire logic       sfr_rd,           // Register read strobe.
   input  wire logic [7:0] sfr_wdata,        // Register write data.
   output var  logic [7:0] sfr_rdata,        // Register read data.
   input  wire logic       periph_irq_en,    // Peripheral interrupt enable.
   input  wire logic       global_irq_en,    // Global interrupt enable.
   output var  logic       irq_request,      // Interrupt request to the core.
   output var  logic [15:0] irq_vector,      // Interrupt vector address.
   input  wire logic       serial_data_in,   // Data pin level.
   output var  logic       serial_data_out,  // Data pin drive value.
   output var  logic       serial_data_oe,   // Data pin drive enable.
   input  wire logic       serial_clock_in,  // Clock pin level.
   output var  logic       serial_clock_out, // Clock pin drive value.
   output var  logic       serial_clock_oe   // Clock pin drive enable.
);

   localparam int FILT_CYCLES = (`TW_FILTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

   initial begin
      if (LINK_PERIOD_PS <= 0 || FILT_CYCLES > 255) begin
         $error("LINK_PERIOD_PS out of range");
      end
   end

   //---------------------------------------------------------------------------
   // Link side: synchronise and filter both lines.
   //---------------------------------------------------------------------------
   logic [1:0] link_rst_sync;
   logic [1:0] pin_raw;
   logic [1:0] filt_level;
   logic [1:0] sys_sync1;
   logic [1:0] sys_sync2;

   assign pin_raw = {serial_clock_in, serial_data_in};

   always_ff @(posedge link_clk) begin
      link_rst_sync <= {link_rst_sync[0], reset};
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         logic       s1;
         logic       s2;
         logic [7:0] run;
         always_ff @(posedge link_clk) begin
            s1 <= pin_raw[gi];
            s2 <= s1;
         end
         always_ff @(posedge link_clk) begin
            if (link_rst_sync[1]) begin
               run           <= 8'h00;
               filt_level[gi] <= 1'b1;
            end else if (s2 == filt_level[gi]) begin
               run <= 8'h00;
            end else if (run >= 8'(FILT_CYCLES - 1)) begin
               run            <= 8'h00;
               filt_level[gi] <= s2;
            end else begin
               run <= run + 8'h01;
            end
         end
         always_ff @(posedge sys_clk) begin
            sys_sync1[gi] <= filt_level[gi];
            sys_sync2[gi] <= sys_sync1[gi];
         end
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Line events on the core clock.
   //---------------------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic scl_q;
   logic sda_q;
   logic ev_start;
   logic ev_stop;
   logic ev_rise;
   logic ev_fall;

   assign scl_s = sys_sync2[1];
   assign sda_s = sys_sync2[0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign ev_start = scl_s & scl_q & sda_q & ~sda_s;
   assign ev_stop  = scl_s & scl_q & ~sda_q & sda_s;
   assign ev_rise  = scl_s & ~scl_q;
   assign ev_fall  = ~scl_s & scl_q;

   //---------------------------------------------------------------------------
   // Software registers.
   //---------------------------------------------------------------------------
   logic [6:0] slave_addr [4];
   logic       role_select;
   logic       iface_reset_bit;
   logic       stop_irq_enable;
   logic       sw_data_out;
   logic       sw_data_drive_en;
   logic       sw_clock_out;
   logic       sw_data_in;
   logic       wr_ctrl;
   logic       data_access;

   assign wr_ctrl     = sfr_wr && sfr_addr == `TW_ADDR_CONTROL;
   assign data_access = (sfr_wr || sfr_rd) && sfr_addr == `TW_ADDR_DATA;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         slave_addr[0] <= 7'(`TW_RST_FIRST);
         slave_addr[1] <= 7'(`TW_RST_OTHER);
         slave_addr[2] <= 7'(`TW_RST_OTHER);
         slave_addr[3] <= 7'(`TW_RST_OTHER);
      end else if (sfr_wr) begin
         unique case (sfr_addr)
            `TW_ADDR_FIRST:  slave_addr[0] <= sfr_wdata[6:0];
            `TW_ADDR_SECOND: slave_addr[1] <= sfr_wdata[6:0];
            `TW_ADDR_THIRD:  slave_addr[2] <= sfr_wdata[6:0];
            `TW_ADDR_FOURTH: slave_addr[3] <= sfr_wdata[6:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         role_select      <= 1'b0;
         iface_reset_bit  <= 1'b0;
         stop_irq_enable  <= 1'b0;
         sw_data_out      <= 1'b0;
         sw_data_drive_en <= 1'b0;
         sw_clock_out     <= 1'b0;
      end else if (wr_ctrl) begin
         role_select <= sfr_wdata[`TW_BIT_ROLE];
         // The role bit of the same write selects which view the other bits load.
         if (sfr_wdata[`TW_BIT_ROLE]) begin
            sw_data_out      <= sfr_wdata[`TW_BIT_HI];
            sw_data_drive_en <= sfr_wdata[`TW_BIT_MID];
            sw_clock_out     <= sfr_wdata[`TW_BIT_SRC_HI];
         end else begin
            stop_irq_enable <= sfr_wdata[`TW_BIT_HI];
            iface_reset_bit <= sfr_wdata[`TW_BIT_RESET];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sw_data_in <= 1'b0;
      end else if (role_select && !sw_data_drive_en && ev_rise) begin
         sw_data_in <= sda_s;
      end
   end

   //---------------------------------------------------------------------------
   // Slave engine.
   //---------------------------------------------------------------------------
   tw_state_type state;
   logic [3:0]   bit_cnt;
   logic [7:0]   shift;
   logic [7:0]   serial_byte_data;
   logic         direction_flag;
   logic         byte_done_flag;
   logic         general_call_flag;
   logic [1:0]   irq_source;
   logic         repeated;
   logic         matched;
   logic         drive_low;
   logic         accessed;
   logic         halted;
   logic         engine_off;
   logic         addr_hit;
   logic         gen_call;
   logic         ev_set;
   logic [1:0]   ev_src;
   logic         next_direction;

   assign engine_off = role_select | iface_reset_bit | halted;
   assign gen_call   = shift[7:1] == `TW_GEN_CALL;
   assign addr_hit   = gen_call || shift[7:1] == slave_addr[0] || shift[7:1] == slave_addr[1]
                       || shift[7:1] == slave_addr[2] || shift[7:1] == slave_addr[3];

   always_comb begin
      ev_set = 1'b0;
      ev_src = `TW_SRC_DATA;
      if (!engine_off) begin
         if (ev_stop && matched && stop_irq_enable) begin
            ev_set = 1'b1;
            ev_src = `TW_SRC_STOP;
         end else if (!ev_stop && !ev_start && ev_fall && state == TW_AACK) begin
            ev_set = 1'b1;
            ev_src = repeated ? `TW_SRC_RESTART : `TW_SRC_START;
         end else if (!ev_stop && !ev_start && ev_fall && (state == TW_RACK || state == TW_TACK)) begin
            ev_set = 1'b1;
            ev_src = `TW_SRC_DATA;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state          <= TW_IDLE;
         bit_cnt        <= 4'h0;
         shift          <= 8'h00;
         drive_low      <= 1'b0;
         repeated       <= 1'b0;
         matched        <= 1'b0;
         direction_flag <= 1'b0;
      end else if (engine_off || ev_stop) begin
         state     <= TW_IDLE;
         drive_low <= 1'b0;
         matched   <= 1'b0;
      end else if (ev_start && (state == TW_IDLE || !direction_flag)) begin
         state     <= TW_ADDR;
         repeated  <= state != TW_IDLE;
         bit_cnt   <= 4'h0;
         drive_low <= 1'b0;
      end else begin
         unique case (state)
            TW_IDLE: ;
            TW_ADDR, TW_RX: begin
               if (ev_rise) begin
                  shift   <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (ev_fall && bit_cnt == `TW_BITS_BYTE) begin
                  if (state == TW_RX || addr_hit) begin
                     state     <= state == TW_RX ? TW_RACK : TW_AACK;
                     drive_low <= 1'b1;
                  end else begin
                     state <= TW_IDLE;
                  end
                  if (state == TW_ADDR && addr_hit) begin
                     matched        <= 1'b1;
                     direction_flag <= shift[0];
                  end
               end
            end
            TW_AACK, TW_RACK: begin
               if (ev_fall) begin
                  state     <= TW_HOLD;
                  drive_low <= 1'b0;
               end
            end
            TW_TX: begin
               if (ev_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (ev_fall) begin
                  if (bit_cnt == `TW_BITS_BYTE) begin
                     state     <= TW_TACK;
                     drive_low <= 1'b0;
                  end else begin
                     shift     <= {shift[6:0], 1'b0};
                     drive_low <= ~shift[6];
                  end
               end
            end
            TW_TACK: begin
               if (ev_rise && sda_s) begin
                  state <= TW_IDLE;
               end else if (ev_fall) begin
                  state <= TW_HOLD;
               end
            end
            TW_HOLD: begin
               if (!byte_done_flag) begin
                  bit_cnt <= 4'h0;
                  if (direction_flag) begin
                     state     <= TW_TX;
                     shift     <= serial_byte_data;
                     drive_low <= ~serial_byte_data[7];
                  end else begin
                     state <= TW_RX;
                  end
               end
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Flags, data register and halt on double access.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset || iface_reset_bit) begin
         byte_done_flag <= 1'b0;
         irq_source     <= `TW_SRC_START;
      end else if (ev_set) begin
         byte_done_flag <= 1'b1;
         irq_source     <= ev_src;
      end else if (data_access) begin
         byte_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         general_call_flag <= 1'b0;
      end else if (ev_set && state == TW_AACK && gen_call) begin
         general_call_flag <= 1'b1;
      end else if (wr_ctrl && !role_select && !sfr_wdata[`TW_BIT_MID]) begin
         general_call_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serial_byte_data <= `TW_RST_DATA;
      end else if (ev_set && (state == TW_AACK || state == TW_RACK)) begin
         serial_byte_data <= shift;
      end else if (sfr_wr && sfr_addr == `TW_ADDR_DATA) begin
         serial_byte_data <= sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || iface_reset_bit) begin
         accessed <= 1'b0;
         halted   <= 1'b0;
      end else if (ev_set) begin
         accessed <= 1'b0;
      end else if (data_access) begin
         accessed <= 1'b1;
         if (accessed && !role_select) begin
            halted <= 1'b1;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Register reads, interrupt and pins.
   //---------------------------------------------------------------------------
   assign next_direction = direction_flag;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            `TW_ADDR_FIRST:   sfr_rdata <= {1'b0, slave_addr[0]};
            `TW_ADDR_SECOND:  sfr_rdata <= {1'b0, slave_addr[1]};
            `TW_ADDR_THIRD:   sfr_rdata <= {1'b0, slave_addr[2]};
            `TW_ADDR_FOURTH:  sfr_rdata <= {1'b0, slave_addr[3]};
            `TW_ADDR_DATA:    sfr_rdata <= serial_byte_data;
            `TW_ADDR_CONTROL: begin
               if (role_select) begin
                  sfr_rdata <= {sw_data_out, sw_data_drive_en, sw_clock_out, sw_data_in, 1'b1, 3'h0};
               end else begin
                  sfr_rdata <= {stop_irq_enable, general_call_flag, irq_source, 1'b0,
                                iface_reset_bit, next_direction, byte_done_flag};
               end
            end
            default:          sfr_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_request <= 1'b0;
         irq_vector  <= `TW_IRQ_VECTOR;
      end else begin
         irq_request <= byte_done_flag & periph_irq_en & global_irq_en;
         irq_vector  <= `TW_IRQ_VECTOR;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serial_data_out  <= 1'b0;
         serial_data_oe   <= 1'b0;
         serial_clock_out <= 1'b0;
         serial_clock_oe  <= 1'b0;
      end else if (role_select) begin
         serial_clock_out <= sw_clock_out;
         serial_clock_oe  <= 1'b1;
         serial_data_out  <= sw_data_out;
         serial_data_oe   <= sw_data_drive_en;
      end else begin
         serial_clock_out <= 1'b0;
         serial_clock_oe  <= state == TW_HOLD && !engine_off;
         serial_data_out  <= 1'b0;
         serial_data_oe   <= drive_low && !engine_off;
      end
   end

endmodule
`default_nettype wire

// file: verif/tw_two_wire_asserts.sv
// Concurrent checks on the ports of the two-wire block.
`timescale 1ns/1ps
`default_nettype none
module tw_two_wire_asserts (
   input wire logic        sys_clk,          // Core clock.
   input wire logic        reset,            // Synchronous reset.
   input wire logic [7:0]  sfr_addr,         // Register address.
   input wire logic        sfr_wr,           // Write strobe.
   input wire logic        sfr_rd,           // Read strobe.
   input wire logic [7:0]  sfr_wdata,        // Write data.
   input wire logic        periph_irq_en,    // Peripheral enable.
   input wire logic        global_irq_en,    // Global enable.
   input wire logic        irq_request,      // Interrupt request.
   input wire logic [15:0] irq_vector,       // Interrupt vector.
   input wire logic        serial_data_out,  // Data drive value.
   input wire logic        serial_data_oe,   // Data drive enable.
   input wire logic        serial_clock_in,  // Clock pin level.
   input wire logic        serial_clock_out, // Clock drive value.
   input wire logic        serial_clock_oe   // Clock drive enable.
);
   logic [7:0] last_ctl;
   logic [2:0] ctl_age;
   logic [2:0] dat_age;
   wire logic  ctl_wr  = sfr_wr && sfr_addr == 8'he8;
   wire logic  dat_acc = (sfr_wr || sfr_rd) && sfr_addr == 8'h9a;

   // Ages saturate at seven.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         last_ctl <= 8'h00;
         ctl_age  <= 3'h7;
      end else if (ctl_wr) begin
         last_ctl <= sfr_wdata;
         ctl_age  <= 3'h0;
      end else if (ctl_age != 3'h7) begin
         ctl_age <= ctl_age + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dat_age <= 3'h7;
      end else if (dat_acc) begin
         dat_age <= 3'h0;
      end else if (dat_age != 3'h7) begin
         dat_age <= dat_age + 3'h1;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_master_clk_drive: assert property (ctl_age >= 3'h3 && last_ctl[3] |->
      serial_clock_oe && serial_clock_out == last_ctl[5]) else $error("clock pin not following clock bit");
   chk_master_data_drive: assert property (ctl_age >= 3'h3 && last_ctl[3] |->
      serial_data_oe == last_ctl[6] && (!last_ctl[6] || serial_data_out == last_ctl[7]))
      else $error("data pin not following data bits");
   chk_irq_gating: assert property (irq_request |-> $past(periph_irq_en) && $past(global_irq_en))
      else $error("interrupt without both enables");
   chk_irq_vector: assert property (irq_request |-> irq_vector == 16'h003b)
      else $error("wrong interrupt vector");
   chk_access_drops_irq: assert property (dat_acc && !last_ctl[3] |-> ##2 !irq_request)
      else $error("data access left interrupt pending");
   chk_stretch_hold: assert property (irq_request && !serial_clock_in && !last_ctl[3] && dat_age >= 3'h3 |->
      serial_clock_oe && !serial_clock_out) else $error("clock not held during pending byte");
   chk_slave_open_drain: assert property (!last_ctl[3] && ctl_age >= 3'h3 |->
      (!serial_data_oe || !serial_data_out) && (!serial_clock_oe || !serial_clock_out))
      else $error("slave drove a line high");
   chk_reset_pins: assert property ($fell(reset) |-> !serial_clock_oe && !serial_data_oe && !irq_request)
      else $error("pins driven after reset");
   chk_iface_reset_idle: assert property (ctl_wr && sfr_wdata[2] && !sfr_wdata[3] && !last_ctl[3] |->
      ##3 !irq_request && !serial_clock_oe && !serial_data_oe) else $error("reset bit left engine busy");

   cov_stretch: cover property (irq_request && serial_clock_oe);
   cov_master: cover property (ctl_wr && sfr_wdata[3]);
   cov_service: cover property (dat_acc && irq_request);
endmodule

bind tw_two_wire tw_two_wire_asserts u_chk (.*);
`default_nettype wire

// file: verif/tw_bus_master.sv
// Behavioural two-wire bus master on the far side of the link.
`timescale 1ns/1ps
`default_nettype none
module tw_bus_master #(
   parameter int QUARTER_NS = 1500
) (
   input  wire logic scl_in,  // Clock line level.
   input  wire logic sda_in,  // Data line level.
   output var  logic scl_low, // Pulls clock line low.
   output var  logic sda_low  // Pulls data line low.
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // Releases the clock and waits, bounded, while the slave stretches it.
   task automatic rise();
      int n;
      n = 0;
      #QUARTER_NS scl_low = 1'b0;
      while (scl_in !== 1'b1 && n < 3000) begin
         #100;
         n++;
      end
   endtask

   task automatic bit_io(input logic drive_low, output logic v);
      #QUARTER_NS sda_low = drive_low;
      rise();
      #QUARTER_NS v = sda_in;
      #QUARTER_NS scl_low = 1'b1;
   endtask

   task automatic start();
      #QUARTER_NS sda_low = 1'b0;
      rise();
      #QUARTER_NS sda_low = 1'b1;
      #QUARTER_NS scl_low = 1'b1;
   endtask

   task automatic stop();
      #QUARTER_NS sda_low = 1'b1;
      rise();
      #QUARTER_NS sda_low = 1'b0;
      #QUARTER_NS;
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack_n);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         bit_io(!b[i], v);
      end
      bit_io(1'b0, ack_n);
   endtask

   task automatic rd_byte(input logic nack, output logic [7:0] b);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b0, b[i]);
      end
      bit_io(!nack, v);
      sda_low = 1'b0;
   endtask

   task automatic hold_data(input logic low);
      sda_low = low;
   endtask
endmodule
`default_nettype wire

// file: verif/tw_two_wire_tb_top.sv
// Self-checking testbench of the two-wire block.
`timescale 1ns/1ps
`default_nettype none
module tw_two_wire_tb_top;
   logic sys_clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rbuf, b;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, periph_irq_en = 1'b0, global_irq_en = 1'b0;
   logic irq_request, sdo, sdoe, sco, scoe, m_scl_low, m_sda_low, ack;
   logic [15:0] irq_vector;
   int err_count = 0, check_count = 0;
   // Both lines have pull-ups; any party pulling low wins.
   wire logic scl_line = !((scoe && !sco) || m_scl_low);
   wire logic sda_line = !((sdoe && !sdo) || m_sda_low);

   tw_two_wire #(.LINK_PERIOD_PS(6000)) uut (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .periph_irq_en(periph_irq_en), .global_irq_en(global_irq_en), .irq_request(irq_request),
      .irq_vector(irq_vector), .serial_data_in(sda_line), .serial_data_out(sdo), .serial_data_oe(sdoe),
      .serial_clock_in(scl_line), .serial_clock_out(sco), .serial_clock_oe(scoe));
   tw_bus_master m (.scl_in(scl_line), .sda_in(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low));

   always #50 sys_clk = ~sys_clk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   task automatic conclude();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      @(negedge sys_clk);
      d = sfr_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      cmp8(d, e);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_request !== 1'b1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      cmp1(irq_request, 1'b1);
   endtask

   task automatic t_regs();
      rdc(8'h9b, 8'h55);
      rdc(8'h91, 8'h7f);
      rdc(8'h92, 8'h7f);
      rdc(8'h93, 8'h7f);
      rdc(8'h9a, 8'h00);
      rdc(8'he8, 8'h00);
      wr(8'h91, 8'hc3);
      rdc(8'h91, 8'h43);
      wr(8'h80, 8'h12);
      rdc(8'h80, 8'h00);
   endtask

   task automatic t_slave_rx();
      wr(8'he8, 8'h80);
      m.start();
      m.wr_byte(8'haa, ack);
      cmp1(ack, 1'b0);
      wait_irq();
      rdc(8'he8, 8'h81);
      cmp1(scoe, 1'b1);
      global_irq_en = 1'b0;
      idle(3);
      cmp1(irq_request, 1'b0);
      global_irq_en = 1'b1;
      rdc(8'h9a, 8'haa);
      idle(3);
      cmp1(irq_request, 1'b0);
      m.wr_byte(8'h3c, ack);
      cmp1(ack, 1'b0);
      wait_irq();
      rdc(8'he8, 8'ha1);
      rdc(8'h9a, 8'h3c);
      m.stop();
      wait_irq();
      rdc(8'he8, 8'hb1);
      rd(8'h9a, rbuf);
   endtask

   task automatic t_restart_tx();
      wr(8'he8, 8'h00);
      wr(8'h93, 8'h21);
      m.start();
      m.wr_byte(8'haa, ack);
      wait_irq();
      rd(8'h9a, rbuf);
      m.start();
      m.wr_byte(8'h43, ack);
      cmp1(ack, 1'b0);
      wait_irq();
      rdc(8'he8, 8'h13);
      wr(8'h9a, 8'h96);
      m.rd_byte(1'b1, b);
      cmp8(b, 8'h96);
      idle(50);
      cmp1(irq_request, 1'b0);
      m.stop();
      idle(50);
      cmp1(irq_request, 1'b0);
   endtask

   task automatic t_gc_nomatch();
      m.start();
      m.wr_byte(8'h20, ack);
      cmp1(ack, 1'b1);
      m.stop();
      cmp1(irq_request, 1'b0);
      m.start();
      m.wr_byte(8'h00, ack);
      cmp1(ack, 1'b0);
      wait_irq();
      rdc(8'he8, 8'h41);
      rd(8'h9a, rbuf);
      wr(8'he8, 8'h00);
      rdc(8'he8, 8'h00);
      m.stop();
      idle(50);
      cmp1(irq_request, 1'b0);
   endtask

   task automatic t_halt();
      m.start();
      m.wr_byte(8'haa, ack);
      wait_irq();
      rd(8'h9a, rbuf);
      rd(8'h9a, rbuf);
      m.wr_byte(8'h11, ack);
      idle(50);
      cmp1(irq_request, 1'b0);
      wr(8'he8, 8'h04);
      rdc(8'he8, 8'h04);
      cmp1(scoe, 1'b0);
      wr(8'he8, 8'h00);
      m.stop();
      m.start();
      m.wr_byte(8'haa, ack);
      cmp1(ack, 1'b0);
      wait_irq();
      rd(8'h9a, rbuf);
      m.stop();
   endtask

   task automatic t_master();
      wr(8'he8, 8'he8);
      idle(4);
      cmp8({scoe, sco, sdoe, sdo}, 8'h0f);
      wr(8'he8, 8'h48);
      idle(4);
      cmp8({scoe, sco, sdoe, sdo}, 8'h0a);
      wr(8'he8, 8'h08);
      idle(4);
      cmp1(sdoe, 1'b0);
      m.hold_data(1'b1);
      idle(10);
      wr(8'he8, 8'h28);
      idle(10);
      rdc(8'he8, 8'h28);
      m.hold_data(1'b0);
      idle(10);
      rdc(8'he8, 8'h28);
      wr(8'he8, 8'h08);
      wr(8'he8, 8'h28);
      idle(10);
      rdc(8'he8, 8'h38);
      wr(8'he8, 8'h00);
      rdc(8'he8, 8'h00);
   endtask

   initial begin
      #3_000_000;
      err_count++;
      conclude();
   end

   initial begin
      idle(10);
      reset = 1'b0;
      periph_irq_en = 1'b1;
      global_irq_en = 1'b1;
      idle(40);
      t_regs();
      t_slave_rx();
      t_restart_tx();
      t_gc_nomatch();
      t_halt();
      t_master();
      conclude();
   end
endmodule
`default_nettype wire
